/* hw/dio_defines.svh */
// Constants of the drive I/O signal channels: register offsets, reset values, codes, timing.
// Assumes inclusion by bare name from every design file that needs a number.
`ifndef DIO_DEFINES_SVH
`define DIO_DEFINES_SVH

// ==========================================================
// Timing
`define DIO_CLK_PERIOD_NS  10
`define DIO_CLK_DIV_NS     10
`define DIO_T_REFRESH_US   1000
`define DIO_T_SAMPLE_MS    3'd4
`define DIO_MS_CYCLES      ((`DIO_T_REFRESH_US * 1000) / `DIO_CLK_DIV_NS)

// ==========================================================
// Register offsets (byte addresses)
`define DIO_A_BO_SRC    8'h00
`define DIO_A_BO_INV    8'h04
`define DIO_A_BO_STATE  8'h08
`define DIO_A_IN_FILT   8'h0C
`define DIO_A_IN_TYPE   8'h10
`define DIO_A_IN_GAIN   8'h14
`define DIO_A_IN_OFFS   8'h18
`define DIO_A_IN_DZ     8'h1C
`define DIO_A_WB_DELAY  8'h20
`define DIO_A_IN_STAT   8'h24
`define DIO_A_IN_VALUE  8'h28
`define DIO_A_OUT_SRC   8'h2C
`define DIO_A_OUT_ABS   8'h30
`define DIO_A_OUT_FILT  8'h34
`define DIO_A_OUT_GAIN  8'h38
`define DIO_A_OUT_OFFS  8'h3C
`define DIO_A_OUT_DZ    8'h40
`define DIO_A_OUT_SIGN  8'h44
`define DIO_A_IRQ_STAT  8'h48
`define DIO_A_IRQ_MASK  8'h4C

// ==========================================================
// Reset values and codes
`define DIO_BO_SRC_RST  16'h0343
`define DIO_GAIN_RST    16'h0100
`define DIO_DELAY_RST   16'h2710
`define DIO_SW1_CODE    12'h034
`define DIO_SW2_CODE    12'h035
`define DIO_SRC_FREQ    16'h0015
`define DIO_SRC_CURR    16'h001B
`define DIO_SRC_AIN     16'h02F3
`define DIO_AIN_MID     16'sh0200
`define DIO_DAC_MAX     16'sh03FF
`define DIO_FRAC        8
`define DIO_IRQ_WB      0
`define DIO_IRQ_DOUT    1
`define DIO_IRQ_SIGN    2
`define DIO_TYPE_BIP    0
`define DIO_TYPE_WBEN   1

`endif

/* hw/dio_pkg.sv */
// Types shared by the drive I/O channel modules.
// Assumes dio_defines.svh carries every number.
package dio_pkg;
  typedef logic signed [15:0] dio_val_t;
  typedef logic        [15:0] dio_word_t;
  typedef logic        [3:0]  dio_shift_t;
endpackage

/* hw/dio_stage_if.sv */
// Carrier between the channel top and one filter/scale/dead-zone stage.
// Assumes one clock domain; the top drives configuration and samples.
`timescale 1ns/100ps
interface dio_stage_if;
  import dio_pkg::*;
  dio_shift_t filt_shift;
  dio_val_t   gain;
  dio_val_t   offset;
  dio_word_t  dead_zone;
  logic       strobe;
  dio_val_t   x;
  dio_val_t   y;
  logic       done;
  modport ctl   (output filt_shift, gain, offset, dead_zone, strobe, x, input y, done);
  modport stage (input filt_shift, gain, offset, dead_zone, strobe, x, output y, done);
endinterface

/* hw/dio_stage.sv */
// One signal chain: first-order lag filter, scaling, dead zone.
// Assumes strobe is a one-cycle pulse at the sample rate; result follows two cycles later.
`timescale 1ns/100ps
`include "dio_defines.svh"
module dio_stage (
  input  wire logic  pclk,
  input  wire logic  presetn,
  dio_stage_if.stage sif
);
  import dio_pkg::*;

  // ==========================================================
  // Filter: y += (x - y) >> shift, extra fraction bits keep small steps
  logic signed [23:0] filt;
  logic               strobe_d;
  wire  signed [23:0] x_ext   = {sif.x, 8'h00};
  wire  signed [23:0] diff    = x_ext - filt;
  wire  signed [23:0] step    = diff >>> sif.filt_shift;
  wire  signed [23:0] next_filt = filt + step;
  wire  dio_val_t     filt_int = filt[23:`DIO_FRAC];
  wire  signed [31:0] prod    = filt_int * sif.gain;
  wire  dio_val_t     scaled  = dio_val_t'(prod[23:8] + sif.offset);
  wire  dio_word_t    mag     = scaled[15] ? dio_word_t'(-scaled) : dio_word_t'(scaled);
  wire  dio_val_t     zoned   = (mag < sif.dead_zone) ? 16'sh0000 : scaled;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt     <= 24'sh000000;
      strobe_d <= 1'b0;
      sif.y    <= 16'sh0000;
      sif.done <= 1'b0;
    end else begin
      if (sif.strobe)
        filt <= next_filt;
      strobe_d <= sif.strobe;
      sif.done <= strobe_d;
      if (strobe_d)
        sif.y <= zoned;
    end
  end
endmodule

/* hw/dio_chan.sv */
// Drive I/O signal channels: binary output, analog input, analog output, APB registers.
// Assumes status words, ADC sample and connector values are synchronous to pclk.
`timescale 1ns/100ps
`include "dio_defines.svh"

// Operation
// - refresh binary output every 1 ms
// - binary output source is parameter plus bit
// - codes 52.x and 53.x pick status bits
// - sample analog input every 4 ms, 10 bits
// - input passes filter, scaling, dead zone
// - filter is first-order lag, time configurable
// - below half dead zone for delay: fault
// - monitoring needs enable and nonzero dead zone
// - monitoring only for unipolar input
// - update analog output every 4 ms, 10 bits
// - output selected connector value
// - output passes filter, scaling, dead zone
// - absolute option feeds magnitude to scaling
// - sign bit set for negative original value with absolute option on
module dio_chan #(
  parameter int MS_CYCLES = `DIO_MS_CYCLES
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire dio_pkg::dio_word_t status_word1,
  input  wire dio_pkg::dio_word_t status_word2,
  input  wire logic [9:0]         adc_sample,
  input  wire dio_pkg::dio_val_t  conn_freq,
  input  wire dio_pkg::dio_val_t  conn_current,
  output logic                    relay_drive,
  output logic                    adc_strobe,
  output logic [9:0]              dac_value,
  output logic                    dac_update,
  output logic                    wire_break_fault,
  output logic                    irq
);
  import dio_pkg::*;

  // ==========================================================
  // Registers
  dio_word_t  binary_output_source;
  logic       binary_output_invert;
  logic       binary_output_state;
  dio_shift_t input_filter_time;
  logic [1:0] input_type_config;
  dio_val_t   in_gain;
  dio_val_t   in_offset;
  dio_word_t  input_dead_zone_width;
  dio_word_t  wire_break_delay;
  logic       wire_broken;
  dio_val_t   in_value;
  dio_word_t  analog_output_source;
  logic       output_absolute_option;
  dio_shift_t out_filt;
  dio_val_t   out_gain;
  dio_val_t   out_offset;
  dio_word_t  out_dz;
  logic       output_sign_status;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;

  // ==========================================================
  // Time base: 1 ms tick and 4 ms sample tick
  logic [31:0] ms_cnt;
  logic [2:0]  smp_cnt;
  wire         ms_tick  = (ms_cnt == 32'(MS_CYCLES - 1));
  wire         smp_tick = ms_tick && (smp_cnt == `DIO_T_SAMPLE_MS - 3'd1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt  <= 32'h0;
      smp_cnt <= 3'h0;
    end else begin
      ms_cnt <= ms_tick ? 32'h0 : ms_cnt + 32'h1;
      if (ms_tick)
        smp_cnt <= smp_tick ? 3'h0 : smp_cnt + 3'h1;
    end
  end

  // ==========================================================
  // Binary output
  wire [11:0] bo_param   = binary_output_source[15:4];
  wire [3:0]  bo_bit     = binary_output_source[3:0];
  wire dio_word_t bo_word = (bo_param == `DIO_SW1_CODE) ? status_word1 :
                            (bo_param == `DIO_SW2_CODE) ? status_word2 : 16'h0000;
  wire        bo_sel     = bo_word[bo_bit];
  wire        next_bo    = bo_sel ^ binary_output_invert;
  wire        bo_changed = ms_tick && (next_bo != binary_output_state);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      binary_output_state <= 1'b0;
    else if (ms_tick)
      binary_output_state <= next_bo;
  end
  assign relay_drive = binary_output_state;

  // ==========================================================
  // Analog input chain
  dio_stage_if ain_if ();
  dio_stage_if aout_if ();

  wire        in_bipolar = input_type_config[`DIO_TYPE_BIP];
  wire dio_val_t raw_in  = in_bipolar ? dio_val_t'({6'h00, adc_sample}) - `DIO_AIN_MID
                                      : dio_val_t'({6'h00, adc_sample});
  logic [9:0] adc_hold;
  logic       adc_valid;

  assign ain_if.filt_shift = input_filter_time;
  assign ain_if.gain       = in_gain;
  assign ain_if.offset     = in_offset;
  assign ain_if.dead_zone  = input_dead_zone_width;
  assign ain_if.strobe     = smp_tick;
  assign ain_if.x          = raw_in;
  assign adc_strobe        = smp_tick;

  dio_stage u_ain (
    .pclk    (pclk),
    .presetn (presetn),
    .sif     (ain_if.stage)
  );

  // ==========================================================
  // Wire breakage monitoring
  wire        wb_active = !in_bipolar && input_type_config[`DIO_TYPE_WBEN]
                          && (input_dead_zone_width != 16'h0000);
  // Source must keep normal values above this threshold when monitoring is on
  wire        wb_below  = adc_valid && ({6'h00, adc_hold} < (input_dead_zone_width >> 1));
  dio_word_t  wb_cnt;
  wire        wb_hit    = wb_active && wb_below && (wb_cnt >= wire_break_delay);
  wire        wb_event  = wb_hit && !wire_broken;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_hold    <= 10'h000;
      adc_valid   <= 1'b0;
      wb_cnt      <= 16'h0000;
      wire_broken <= 1'b0;
      in_value    <= 16'sh0000;
    end else begin
      if (smp_tick) begin
        adc_hold  <= adc_sample;
        adc_valid <= 1'b1;
      end
      if (!(wb_active && wb_below))
        wb_cnt <= 16'h0000;
      else if (ms_tick && wb_cnt != 16'hFFFF)
        wb_cnt <= wb_cnt + 16'h0001;
      wire_broken <= wb_hit;
      if (ain_if.done)
        in_value <= ain_if.y;
    end
  end
  assign wire_break_fault = wire_broken;

  // ==========================================================
  // Analog output chain
  wire dio_val_t out_sel = (analog_output_source == `DIO_SRC_FREQ) ? conn_freq :
                           (analog_output_source == `DIO_SRC_CURR) ? conn_current :
                           (analog_output_source == `DIO_SRC_AIN)  ? in_value : 16'sh0000;
  wire        out_neg    = out_sel[15];
  wire dio_val_t out_fold = (output_absolute_option && out_neg) ? -out_sel : out_sel;
  wire dio_val_t out_y    = aout_if.y;
  wire [9:0]  dac_next    = out_y[15] ? 10'h000 :
                            (out_y > `DIO_DAC_MAX) ? 10'h3FF : out_y[9:0];
  wire        sign_event  = smp_tick && output_absolute_option && out_neg;

  assign aout_if.filt_shift = out_filt;
  assign aout_if.gain       = out_gain;
  assign aout_if.offset     = out_offset;
  assign aout_if.dead_zone  = out_dz;
  assign aout_if.strobe     = smp_tick;
  assign aout_if.x          = out_fold;

  dio_stage u_aout (
    .pclk    (pclk),
    .presetn (presetn),
    .sif     (aout_if.stage)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_value          <= 10'h000;
      dac_update         <= 1'b0;
      output_sign_status <= 1'b0;
    end else begin
      dac_update <= aout_if.done;
      if (aout_if.done)
        dac_value <= dac_next;
      if (smp_tick)
        output_sign_status <= output_absolute_option && out_neg;
    end
  end

  // ==========================================================
  // APB slave: zero wait states, read data latched in setup
  wire        setup  = psel && !penable;
  wire        wr     = psel && penable && pwrite;
  wire        hit_bo_src = (paddr == `DIO_A_BO_SRC);
  wire        hit_bo_inv = (paddr == `DIO_A_BO_INV);
  wire        hit_in_flt = (paddr == `DIO_A_IN_FILT);
  wire        hit_in_typ = (paddr == `DIO_A_IN_TYPE);
  wire        hit_in_gn  = (paddr == `DIO_A_IN_GAIN);
  wire        hit_in_of  = (paddr == `DIO_A_IN_OFFS);
  wire        hit_in_dz  = (paddr == `DIO_A_IN_DZ);
  wire        hit_wb_dl  = (paddr == `DIO_A_WB_DELAY);
  wire        hit_out_sr = (paddr == `DIO_A_OUT_SRC);
  wire        hit_out_ab = (paddr == `DIO_A_OUT_ABS);
  wire        hit_out_fl = (paddr == `DIO_A_OUT_FILT);
  wire        hit_out_gn = (paddr == `DIO_A_OUT_GAIN);
  wire        hit_out_of = (paddr == `DIO_A_OUT_OFFS);
  wire        hit_out_dz = (paddr == `DIO_A_OUT_DZ);
  wire        hit_irq_st = (paddr == `DIO_A_IRQ_STAT);
  wire        hit_irq_mk = (paddr == `DIO_A_IRQ_MASK);
  wire        hit_ro     = (paddr == `DIO_A_BO_STATE) || (paddr == `DIO_A_IN_STAT) ||
                           (paddr == `DIO_A_IN_VALUE) || (paddr == `DIO_A_OUT_SIGN);
  wire        mapped     = hit_bo_src || hit_bo_inv || hit_in_flt || hit_in_typ || hit_in_gn ||
                           hit_in_of || hit_in_dz || hit_wb_dl || hit_out_sr || hit_out_ab ||
                           hit_out_fl || hit_out_gn || hit_out_of || hit_out_dz ||
                           hit_irq_st || hit_irq_mk || hit_ro;
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0;
    unique case (paddr)
      `DIO_A_BO_SRC:   rd_mux = {16'h0, binary_output_source};
      `DIO_A_BO_INV:   rd_mux = {31'h0, binary_output_invert};
      `DIO_A_BO_STATE: rd_mux = {31'h0, binary_output_state};
      `DIO_A_IN_FILT:  rd_mux = {28'h0, input_filter_time};
      `DIO_A_IN_TYPE:  rd_mux = {30'h0, input_type_config};
      `DIO_A_IN_GAIN:  rd_mux = {16'h0, in_gain};
      `DIO_A_IN_OFFS:  rd_mux = {16'h0, in_offset};
      `DIO_A_IN_DZ:    rd_mux = {16'h0, input_dead_zone_width};
      `DIO_A_WB_DELAY: rd_mux = {16'h0, wire_break_delay};
      `DIO_A_IN_STAT:  rd_mux = {31'h0, wire_broken};
      `DIO_A_IN_VALUE: rd_mux = {16'h0, in_value};
      `DIO_A_OUT_SRC:  rd_mux = {16'h0, analog_output_source};
      `DIO_A_OUT_ABS:  rd_mux = {31'h0, output_absolute_option};
      `DIO_A_OUT_FILT: rd_mux = {28'h0, out_filt};
      `DIO_A_OUT_GAIN: rd_mux = {16'h0, out_gain};
      `DIO_A_OUT_OFFS: rd_mux = {16'h0, out_offset};
      `DIO_A_OUT_DZ:   rd_mux = {16'h0, out_dz};
      `DIO_A_OUT_SIGN: rd_mux = {31'h0, output_sign_status};
      `DIO_A_IRQ_STAT: rd_mux = {29'h0, irq_stat};
      `DIO_A_IRQ_MASK: rd_mux = {29'h0, irq_mask};
      default:         rd_mux = 32'h0;
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Events set sticky bits; a set in the same cycle as a clear wins
  wire [2:0] irq_set = {sign_event, bo_changed, wb_event};
  wire [2:0] irq_clr = (wr && hit_irq_st) ? pwdata[2:0] : 3'h0;
  assign irq = |(irq_stat & irq_mask);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata                 <= 32'h0;
      binary_output_source   <= `DIO_BO_SRC_RST;
      binary_output_invert   <= 1'b0;
      input_filter_time      <= 4'h0;
      input_type_config      <= 2'h0;
      in_gain                <= `DIO_GAIN_RST;
      in_offset              <= 16'sh0000;
      input_dead_zone_width  <= 16'h0000;
      wire_break_delay       <= `DIO_DELAY_RST;
      analog_output_source   <= `DIO_SRC_FREQ;
      output_absolute_option <= 1'b0;
      out_filt               <= 4'h0;
      out_gain               <= `DIO_GAIN_RST;
      out_offset             <= 16'sh0000;
      out_dz                 <= 16'h0000;
      irq_stat               <= 3'h0;
      irq_mask               <= 3'h0;
    end else begin
      if (setup)
        prdata <= rd_mux;
      if (wr && hit_bo_src) binary_output_source   <= pwdata[15:0];
      if (wr && hit_bo_inv) binary_output_invert   <= pwdata[0];
      if (wr && hit_in_flt) input_filter_time      <= pwdata[3:0];
      if (wr && hit_in_typ) input_type_config      <= pwdata[1:0];
      if (wr && hit_in_gn)  in_gain                <= pwdata[15:0];
      if (wr && hit_in_of)  in_offset              <= pwdata[15:0];
      if (wr && hit_in_dz)  input_dead_zone_width  <= pwdata[15:0];
      if (wr && hit_wb_dl)  wire_break_delay       <= pwdata[15:0];
      if (wr && hit_out_sr) analog_output_source   <= pwdata[15:0];
      if (wr && hit_out_ab) output_absolute_option <= pwdata[0];
      if (wr && hit_out_fl) out_filt               <= pwdata[3:0];
      if (wr && hit_out_gn) out_gain               <= pwdata[15:0];
      if (wr && hit_out_of) out_offset             <= pwdata[15:0];
      if (wr && hit_out_dz) out_dz                 <= pwdata[15:0];
      if (wr && hit_irq_mk) irq_mask               <= pwdata[2:0];
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
    end
  end
endmodule

/* testbench/dio_far_side.sv */
// Far-side model: analog sensor feeding the converter, analog receiver taking converter codes.
// Assumes the bench sets the sensor level just after a clock edge.
`timescale 1ns/100ps
module dio_far_side (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [9:0] level,
  input  wire logic       adc_strobe,
  input  wire logic [9:0] dac_value,
  input  wire logic       dac_update,
  output logic      [9:0] adc_sample,
  output logic      [9:0] dac_seen
);
  // ====================
  // Sensor
  // Data is valid only in the sample cycle; elsewhere the inverse, so a late sample reads garbage
  assign adc_sample = adc_strobe ? level : ~level;
  // ====================
  // Receiver
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_seen <= 10'h000;
    end else if (dac_update) begin
      dac_seen <= dac_value;
    end
  end
endmodule

/* testbench/dio_chan_chk.sv */
// Checker for dio_chan: tick spacing, converter timing, bus answers, interrupt release.
// Assumes it is bound to dio_chan and sees only its ports.
`timescale 1ns/100ps
module dio_chan_chk #(
  parameter int MS_CYCLES = 100000
) (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       relay_drive,
  input wire logic       adc_strobe,
  input wire logic [9:0] dac_value,
  input wire logic       dac_update,
  input wire logic       wire_break_fault,
  input wire logic       irq
);
  // ====================
  // Cycles since the last sample tick
  int unsigned since_sample;
  logic        sampled;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_sample <= 0;
      sampled      <= 1'h0;
    end else begin
      since_sample <= adc_strobe ? 0 : since_sample + 1;
      sampled      <= sampled | adc_strobe;
    end
  end
  // ====================
  // Properties
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_relay_tick;
    sampled && $changed(relay_drive) |-> since_sample % MS_CYCLES == 0;
  endproperty
  a_relay_tick: assert property (p_relay_tick) else $error("relay moved off the tick");
  property p_sample_gap;
    sampled && adc_strobe |-> since_sample == 4 * MS_CYCLES - 1;
  endproperty
  a_sample_gap: assert property (p_sample_gap) else $error("sample spacing wrong");
  property p_dac_late;
    dac_update |-> $past(adc_strobe, 3);
  endproperty
  a_dac_late: assert property (p_dac_late) else $error("converter update off slot");
  property p_dac_hold;
    $changed(dac_value) |-> dac_update;
  endproperty
  a_dac_hold: assert property (p_dac_hold) else $error("converter code moved without update");
  property p_fault_after_sample;
    $rose(wire_break_fault) |-> sampled;
  endproperty
  a_fault_after_sample: assert property (p_fault_after_sample) else $error("fault before any sample");
  property p_irq_release;
    $fell(irq) |-> $past(psel && penable && pwrite);
  endproperty
  a_irq_release: assert property (p_irq_release) else $error("interrupt dropped without a write");
  property p_err_access;
    pslverr |-> psel && penable;
  endproperty
  a_err_access: assert property (p_err_access) else $error("error outside access phase");
  property p_ready;
    pready;
  endproperty
  a_ready: assert property (p_ready) else $error("wait state inserted");
  c_relay: cover property ($changed(relay_drive));
  c_dac: cover property (dac_update);
  c_fault: cover property ($rose(wire_break_fault));
  c_irq: cover property ($fell(irq));
endmodule

bind dio_chan dio_chan_chk #(.MS_CYCLES(MS_CYCLES)) dio_chan_chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .pslverr(pslverr), .relay_drive(relay_drive), .adc_strobe(adc_strobe),
  .dac_value(dac_value), .dac_update(dac_update), .wire_break_fault(wire_break_fault), .irq(irq));

/* testbench/dio_chan_tb.sv */
// Self-checking bench for dio_chan: APB registers, binary output, analog input and output.
// Assumes a shortened millisecond of MS cycles and dio_far_side as sensor and receiver.
`timescale 1ns/100ps
`include "dio_defines.svh"
module dio_chan_tb;
  import dio_pkg::*;
  localparam int MS = 20;
  typedef struct {
    dio_word_t   src, sw1, sw2, osrc;
    logic        inv, relay, oabs, sign;
    dio_val_t    conn;
    logic [31:0] dac;
  } dio_row_s;
  // ====================
  // Rows: source, words, out source, invert, relay, abs, sign, connector, converter code
  dio_row_s rows [7] = '{
    '{16'h0343, 16'h0008, 16'h0000, 16'h0015, 1'h0, 1'h1, 1'h0, 1'h0, 16'h012C, 32'h12C},
    '{16'h0343, 16'h0008, 16'h0000, 16'h0015, 1'h1, 1'h0, 1'h0, 1'h0, 16'h07D0, 32'h3FF},
    '{16'h034A, 16'h0400, 16'h0000, 16'h001B, 1'h0, 1'h1, 1'h0, 1'h0, 16'h0064, 32'h000},
    '{16'h034A, 16'hFBFF, 16'h0000, 16'h001B, 1'h0, 1'h0, 1'h1, 1'h1, 16'h0064, 32'h064},
    '{16'h0350, 16'h0000, 16'h0001, 16'h0015, 1'h0, 1'h1, 1'h1, 1'h1, 16'hFF06, 32'h0FA},
    '{16'h035F, 16'h0000, 16'h7FFF, 16'h0015, 1'h1, 1'h1, 1'h1, 1'h0, 16'h00FA, 32'h0FA},
    '{16'h0123, 16'hFFFF, 16'hFFFF, 16'h0000, 1'h0, 1'h0, 1'h0, 1'h0, 16'h01F4, 32'h000}};
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, relay_drive, adc_strobe, dac_update, wire_break_fault, irq;
  dio_word_t   status_word1 = 16'h0, status_word2 = 16'h0;
  dio_val_t    conn_freq = 16'h0, conn_current = 16'h0;
  logic [9:0]  adc_level = 10'h0, adc_sample, dac_value, dac_seen;
  int          num_errors = 0, checked = 0;
  always #5 pclk = ~pclk;
  dio_chan #(.MS_CYCLES(MS)) dio_chan_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .status_word1(status_word1),
    .status_word2(status_word2), .adc_sample(adc_sample), .conn_freq(conn_freq), .conn_current(conn_current),
    .relay_drive(relay_drive), .adc_strobe(adc_strobe), .dac_value(dac_value), .dac_update(dac_update),
    .wire_break_fault(wire_break_fault), .irq(irq));
  dio_far_side dio_far_side_i (
    .pclk(pclk), .presetn(presetn), .level(adc_level), .adc_strobe(adc_strobe),
    .dac_value(dac_value), .dac_update(dac_update), .adc_sample(adc_sample), .dac_seen(dac_seen));
  // ====================
  // Tasks
  task automatic complete_run;
    if (num_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang;
    chk(32'h0, 32'h1);
    complete_run();
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    if (n >= 50) hang();
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Counts sample ticks, then lets the four-cycle pipeline settle
  task automatic wait_samples(input int k);
    for (int n = 0; k > 0; n++) begin
      @(posedge pclk);
      if (adc_strobe === 1'h1) k--;
      if (n > 40 * MS) hang();
    end
    repeat (4) @(posedge pclk);
  endtask
  // ====================
  // Sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    rd_chk(`DIO_A_BO_SRC, 32'h343);
    rd_chk(`DIO_A_IN_GAIN, 32'h100);
    rd_chk(`DIO_A_WB_DELAY, 32'h2710);
    rd_chk(`DIO_A_OUT_SRC, 32'h15);
    apb(1'h1, 8'h50, 32'hFFFFFFFF);
    chk({31'h0, err}, 32'h1);
    rd_chk(8'h50, 32'h0);
    apb(1'h1, `DIO_A_BO_STATE, 32'h1);
    rd_chk(`DIO_A_BO_STATE, 32'h0);
    for (int i = 0; i < 7; i++) begin
      apb(1'h1, `DIO_A_BO_SRC, {16'h0, rows[i].src});
      apb(1'h1, `DIO_A_BO_INV, {31'h0, rows[i].inv});
      apb(1'h1, `DIO_A_OUT_SRC, {16'h0, rows[i].osrc});
      apb(1'h1, `DIO_A_OUT_ABS, {31'h0, rows[i].oabs});
      status_word1 <= rows[i].sw1;
      status_word2 <= rows[i].sw2;
      conn_freq    <= rows[i].conn;
      conn_current <= -rows[i].conn;
      wait_samples(2);
      chk({31'h0, relay_drive}, {31'h0, rows[i].relay});
      rd_chk(`DIO_A_BO_STATE, {31'h0, rows[i].relay});
      chk({22'h0, dac_seen}, rows[i].dac);
      rd_chk(`DIO_A_OUT_SIGN, {31'h0, rows[i].sign});
    end
    rd_chk(`DIO_A_IRQ_STAT, 32'h6);
    apb(1'h1, `DIO_A_IRQ_STAT, 32'h6);
    rd_chk(`DIO_A_IRQ_STAT, 32'h0);
    apb(1'h1, `DIO_A_WB_DELAY, 32'h3);
    apb(1'h1, `DIO_A_IN_DZ, 32'h28);
    adc_level <= 10'h00A;
    for (int t = 0; t < 2; t++) begin
      apb(1'h1, `DIO_A_IN_TYPE, t ? 32'h3 : 32'h0);
      wait_samples(4);
      chk({31'h0, wire_break_fault}, 32'h0);
    end
    // Raise the level before unipolar monitoring starts, or the last low sample would trip it
    adc_level <= 10'h3FF;
    wait_samples(1);
    apb(1'h1, `DIO_A_IN_TYPE, 32'h2);
    wait_samples(1);
    rd_chk(`DIO_A_IN_VALUE, 32'h3FF);
    apb(1'h1, `DIO_A_IN_FILT, 32'h2);
    adc_level <= 10'h12C;
    wait_samples(1);
    rd_chk(`DIO_A_IN_VALUE, 32'h34A);
    apb(1'h1, `DIO_A_IN_FILT, 32'h0);
    adc_level <= 10'h01E;
    wait_samples(2);
    rd_chk(`DIO_A_IN_VALUE, 32'h0);
    adc_level <= 10'h00A;
    wait_samples(1);
    repeat (MS) @(posedge pclk);
    chk({31'h0, wire_break_fault}, 32'h0);
    for (int n = 0; wire_break_fault !== 1'h1; n++) begin
      if (n > 8 * MS) hang();
      @(posedge pclk);
    end
    rd_chk(`DIO_A_IN_STAT, 32'h1);
    chk({31'h0, irq}, 32'h0);
    apb(1'h1, `DIO_A_IRQ_MASK, 32'h1);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'h1, `DIO_A_IN_DZ, 32'h0);
    repeat (3) @(posedge pclk);
    chk({31'h0, wire_break_fault}, 32'h0);
    apb(1'h1, `DIO_A_IRQ_STAT, 32'h1);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    // Non-default gain and offset on the input, processed input as output source
    apb(1'h1, `DIO_A_IN_GAIN, 32'h200);
    apb(1'h1, `DIO_A_IN_OFFS, 32'h5);
    apb(1'h1, `DIO_A_OUT_SRC, 32'h2F3);
    apb(1'h1, `DIO_A_OUT_GAIN, 32'h300);
    apb(1'h1, `DIO_A_OUT_DZ, 32'h40);
    wait_samples(2);
    rd_chk(`DIO_A_IN_VALUE, 32'h19);
    chk({22'h0, dac_seen}, 32'h4B);
    // Widen the output dead zone past the scaled value
    apb(1'h1, `DIO_A_OUT_DZ, 32'h50);
    wait_samples(1);
    chk({22'h0, dac_seen}, 32'h0);
    complete_run();
  end
endmodule
